// *** rtl/pecc_top.sv ***
/*
  Protocol execute controller with cancellation and fixed-buffer send.
  Assumes the host obeys the plain register strobes and that the link
  side reports send and receive progress as one-cycle pulses.
*/
// Design decision made here: the strobed register port.
`default_nettype none
`include "pecc_map.svh"
module pecc_top
  import pecc_pkg::*;
#(
  parameter int unsigned POLL_CYCLES = `PECC_POLL_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic EXEC_REQ,
  input wire logic [3:0] EXEC_NUM,
  input wire logic [4:0] EXEC_CONN,
  input wire logic EXEC_SETTING_OK,
  output logic EXEC_DONE,
  output logic EXEC_ERR,
  output logic [15:0] EXEC_STATUS,
  output logic [3:0] EXEC_COUNT,
  output logic [2:0] PROTO_IDX,
  input wire logic [1:0] PROTO_TYPE,
  output logic TX_REQ,
  input wire logic TX_ACK,
  input wire logic TX_DONE,
  output logic RX_EN,
  input wire logic RX_START,
  input wire logic RX_DONE,
  input wire logic RX_ERR,
  input wire logic [4:0] RX_MATCH,
  output logic RX_DISCARD,
  input wire logic SND_REQ,
  input wire logic [4:0] SND_CONN,
  input wire logic [7:0] SND_UNIT,
  input wire logic SAFETY_CPU,
  output logic SND_TX_REQ,
  input wire logic SND_TX_DONE,
  output logic SND_DONE,
  output logic SND_ERR,
  output logic [15:0] SND_STATUS
);
  pecc_state_t state_reg;
  pecc_state_t state_next;
  logic [2:0] idx_reg;
  logic [3:0] num_reg;
  logic [15:0] cancel_reg;
  logic [15:0] conn_reg;
  logic cpend_reg;
  logic [3:0] count_reg;
  logic [15:0] cstat_reg;
  logic done_reg;
  logic err_reg;
  logic discard_reg;
  logic [15:0] rdata_reg;
  logic [4:0] match_reg [0:7];
  logic fin;
  logic fin_cxl;
  logic [15:0] fin_code;
  logic [3:0] fin_cnt;
  logic idx_inc;
  logic tick;

  // Periodic processing tick
  pecc_tick #(
    .POLL_CYCLES(POLL_CYCLES)
  ) u_tick (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .tick(tick)
  );

  // Fixed-buffer send engine
  pecc_snd_if snd_bus ();
  assign snd_bus.req = SND_REQ;
  assign snd_bus.conn = SND_CONN;
  assign snd_bus.unit = SND_UNIT;
  assign snd_bus.safety = SAFETY_CPU;
  assign snd_bus.tx_done = SND_TX_DONE;
  assign SND_TX_REQ = snd_bus.tx_req;
  assign SND_DONE = snd_bus.done;
  assign SND_ERR = snd_bus.err;
  assign SND_STATUS = snd_bus.status;
  pecc_send u_send (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .snd(snd_bus.eng)
  );

  // Register decode
  wire wr_cancel = REG_WR && (REG_ADDR == `PECC_A_CANCEL);
  wire wr_conn = REG_WR && (REG_ADDR == `PECC_A_CONN);
  wire rd_match = (REG_ADDR & `PECC_MATCH_MASK) == `PECC_A_MATCH;
  wire [15:0] match_word = {11'h000, match_reg[REG_ADDR[2:0]]};
  wire [15:0] state_word = (state_reg == PECC_WTX) ? `PECC_ST_WTX :
                           (state_reg == PECC_SEND) ? `PECC_ST_SEND :
                           (state_reg == PECC_WRX) ? `PECC_ST_WRX :
                           (state_reg == PECC_RECV) ? `PECC_ST_RECV :
                           (state_reg == PECC_CMPL) ? `PECC_ST_CMPL :
                           (state_reg == PECC_NEXT) ? `PECC_ST_CMPL : `PECC_ST_IDLE;
  wire [15:0] rd_word = (REG_ADDR == `PECC_A_STATE) ? state_word :
                        (REG_ADDR == `PECC_A_CANCEL) ? cancel_reg :
                        (REG_ADDR == `PECC_A_COUNT) ? {12'h000, count_reg} :
                        (REG_ADDR == `PECC_A_CSTAT) ? cstat_reg :
                        (REG_ADDR == `PECC_A_CONN) ? conn_reg :
                        rd_match ? match_word : 16'h0000;

  // Start checks
  wire cxl_word = cancel_reg == `PECC_CANCEL_REQ;
  wire idle = state_reg == PECC_IDLE;
  wire start = EXEC_REQ && idle && !cxl_word;
  wire num_bad = (EXEC_NUM == 4'h0) || (EXEC_NUM > `PECC_MAX_PROTO);
  wire conn_rng = (EXEC_CONN != 5'h00) && (EXEC_CONN <= `PECC_MAX_CONN);
  wire [3:0] conn_bit = 4'(EXEC_CONN - 5'h01);
  wire conn_pre = conn_rng && conn_reg[conn_bit];
  wire [15:0] chk_code = num_bad ? `PECC_E_CTRL :
                         !EXEC_SETTING_OK ? `PECC_E_SET :
                         !conn_pre ? `PECC_E_CONN : `PECC_OK;
  wire chk_ok = chk_code == `PECC_OK;

  // Cancel polling
  wire cxl_hit = tick && cxl_word && !idle;
  wire cxl_now = cpend_reg || cxl_hit;
  wire has_tx = PROTO_TYPE[0];
  wire has_rx = PROTO_TYPE[1];
  wire [3:0] done_cnt = {1'b0, idx_reg} + 4'h1;
  wire last = done_cnt == num_reg;
  wire pecc_state_t enter = has_tx ? PECC_WTX : PECC_WRX;

  // Sequencer
  always_comb begin
    state_next = state_reg;
    fin = 1'b0;
    fin_cxl = 1'b0;
    fin_code = `PECC_OK;
    fin_cnt = done_cnt;
    idx_inc = 1'b0;
    case (state_reg)
      PECC_IDLE: begin
        if (start && chk_ok) begin
          state_next = enter;
        end else if (start) begin
          fin = 1'b1;
          fin_code = chk_code;
          fin_cnt = 4'h0;
        end
      end
      PECC_WTX: begin
        if (cxl_now) begin
          fin_cxl = 1'b1;
        end else if (TX_ACK) begin
          state_next = PECC_SEND;
        end
      end
      PECC_SEND: begin
        if (TX_DONE && cxl_now) begin
          fin_cxl = 1'b1;
        end else if (TX_DONE) begin
          state_next = has_rx ? PECC_WRX : PECC_CMPL;
        end
      end
      PECC_WRX: begin
        if (cxl_now) begin
          fin_cxl = 1'b1;
        end else if (RX_ERR) begin
          fin = 1'b1;
          fin_code = `PECC_E_PROTO;
        end else if (RX_START) begin
          state_next = PECC_RECV;
        end
      end
      PECC_RECV: begin
        if (RX_ERR) begin
          fin = 1'b1;
          fin_code = `PECC_E_PROTO;
        end else if (RX_DONE && cxl_now) begin
          fin_cxl = 1'b1;
        end else if (RX_DONE) begin
          state_next = PECC_CMPL;
        end
      end
      PECC_CMPL: begin
        if (last) begin
          fin = 1'b1;
        end else if (cxl_now) begin
          fin_cxl = 1'b1;
        end else begin
          idx_inc = 1'b1;
          state_next = PECC_NEXT;
        end
      end
      PECC_NEXT: begin
        if (cxl_now) begin
          fin_cxl = 1'b1;
        end else begin
          state_next = enter;
        end
      end
      default: begin
        state_next = PECC_IDLE;
      end
    endcase
    if (fin_cxl) begin
      fin = 1'b1;
      fin_code = `PECC_E_CANCEL;
    end
    if (fin) begin
      state_next = PECC_IDLE;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= PECC_IDLE;
      idx_reg <= 3'h0;
      num_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (fin) idx_reg <= 3'h0;
      else if (idx_inc) idx_reg <= idx_reg + 3'h1;
      if (start) num_reg <= EXEC_NUM;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cpend_reg <= 1'b0;
    end else if (fin) begin
      cpend_reg <= 1'b0;
    end else if (cxl_hit) begin
      cpend_reg <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      count_reg <= 4'h0;
      cstat_reg <= `PECC_OK;
    end else begin
      done_reg <= fin;
      err_reg <= fin && (fin_code != `PECC_OK);
      if (fin) count_reg <= fin_cnt;
      if (fin) cstat_reg <= fin_code;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      discard_reg <= 1'b0;
    end else if (start) begin
      discard_reg <= 1'b0;
    end else if (fin_cxl && has_rx) begin
      discard_reg <= 1'b1;
    end
  end

  // Matched receive packet numbers, one word per protocol slot
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_match
      wire hit = (state_reg == PECC_RECV) && RX_DONE && !RX_ERR && (idx_reg == 3'(gi));
      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) match_reg[gi] <= 5'h00;
        else if (start) match_reg[gi] <= 5'h00;
        else if (hit) match_reg[gi] <= RX_MATCH;
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cancel_reg <= 16'h0000;
      conn_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      if (wr_cancel) cancel_reg <= REG_WDATA;
      if (wr_conn) conn_reg <= REG_WDATA;
      if (REG_RD) rdata_reg <= rd_word;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign EXEC_DONE = done_reg;
  assign EXEC_ERR = err_reg;
  assign EXEC_STATUS = cstat_reg;
  assign EXEC_COUNT = count_reg;
  assign PROTO_IDX = idx_reg;
  assign TX_REQ = state_reg == PECC_WTX;
  assign RX_EN = (state_reg == PECC_WRX) || (state_reg == PECC_RECV);
  assign RX_DISCARD = discard_reg;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_cxl_end;
    fin_cxl ##1 (EXEC_DONE && EXEC_ERR);
  endsequence
  sequence s_cxl_wait_send;
    (state_reg == PECC_SEND) && cpend_reg && !TX_DONE;
  endsequence

  property p_cxl_code;
    fin_cxl |=> EXEC_STATUS == `PECC_E_CANCEL && EXEC_ERR && EXEC_DONE;
  endproperty
  a_cxl_code: assert property (p_cxl_code) else $error("cancel code missing");

  property p_cxl_stop;
    s_cxl_end |-> state_reg == PECC_IDLE && idx_reg == 3'h0;
  endproperty
  a_cxl_stop: assert property (p_cxl_stop) else $error("protocols run after cancel");

  property p_cxl_count;
    fin_cxl |=> EXEC_COUNT == {1'b0, $past(idx_reg)} + 4'h1;
  endproperty
  a_cxl_count: assert property (p_cxl_count) else $error("cancel count wrong");

  property p_idle_cxl;
    tick && cxl_word && idle |=> !cpend_reg && !EXEC_DONE;
  endproperty
  a_idle_cxl: assert property (p_idle_cxl) else $error("idle cancel acted");

  property p_discard;
    fin_cxl && has_rx |=> RX_DISCARD;
  endproperty
  a_discard: assert property (p_discard) else $error("receive data not discarded");

  property p_poll;
    $rose(cpend_reg) |-> $past(tick);
  endproperty
  a_poll: assert property (p_poll) else $error("cancel taken outside tick");

  property p_refuse;
    EXEC_REQ && idle && cxl_word |=> idle && !EXEC_DONE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("execute started under cancel");

  property p_wtx_abort;
    (state_reg == PECC_WTX) && cxl_now |=> idle && EXEC_ERR && EXEC_STATUS == `PECC_E_CANCEL;
  endproperty
  a_wtx_abort: assert property (p_wtx_abort) else $error("pending send not aborted");

  property p_send_hold;
    s_cxl_wait_send |=> state_reg == PECC_SEND;
  endproperty
  a_send_hold: assert property (p_send_hold) else $error("send cut short");

  property p_recv_hold;
    (state_reg == PECC_RECV) && cpend_reg && !RX_DONE && !RX_ERR |=> state_reg == PECC_RECV;
  endproperty
  a_recv_hold: assert property (p_recv_hold) else $error("receive cut short");

  property p_done_pulse;
    EXEC_DONE |=> !EXEC_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");

  property p_proto_err;
    (state_reg == PECC_RECV) && RX_ERR |=> EXEC_ERR && EXEC_STATUS == `PECC_E_PROTO;
  endproperty
  a_proto_err: assert property (p_proto_err) else $error("protocol error not reported");
endmodule : pecc_top
`default_nettype wire

// *** rtl/pecc_map.svh ***
/*
  Register offsets, status values, error codes and limits of the
  protocol execute / cancel controller.
  Assumes it is included by bare name from the rtl folder.
*/
`ifndef PECC_MAP_SVH
`define PECC_MAP_SVH
`define PECC_A_STATE 16'h54C0
`define PECC_A_CANCEL 16'h54D3
`define PECC_A_COUNT 16'h5500
`define PECC_A_CSTAT 16'h5501
`define PECC_A_MATCH 16'h5510
`define PECC_MATCH_MASK 16'hFFF8
`define PECC_A_CONN 16'h5520
`define PECC_CANCEL_REQ 16'h0001
`define PECC_OK 16'h0000
`define PECC_E_CTRL 16'hC401
`define PECC_E_SET 16'hC402
`define PECC_E_PROTO 16'hC403
`define PECC_E_CANCEL 16'hC404
`define PECC_E_CONN 16'hC407
`define PECC_E_UNIT 16'hC410
`define PECC_E_OPER 16'h4101
`define PECC_ST_IDLE 16'h0000
`define PECC_ST_WTX 16'h0001
`define PECC_ST_SEND 16'h0002
`define PECC_ST_WRX 16'h0003
`define PECC_ST_RECV 16'h0004
`define PECC_ST_CMPL 16'h0005
`define PECC_MAX_PROTO 4'h8
`define PECC_MAX_CONN 5'h10
`define PECC_MAX_SAFE 5'h08
`define PECC_MAX_UNIT 8'hFE
`define PECC_POLL_CYCLES 16
`endif

// *** rtl/pecc_pkg.sv ***
/*
  Types of the protocol execute / cancel controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pecc_pkg;
  typedef enum logic [2:0] {
    PECC_IDLE = 3'h0,
    PECC_WTX = 3'h1,
    PECC_SEND = 3'h3,
    PECC_WRX = 3'h2,
    PECC_RECV = 3'h6,
    PECC_CMPL = 3'h7,
    PECC_NEXT = 3'h5
  } pecc_state_t;
  typedef enum logic {PECC_S_IDLE = 1'b0, PECC_S_BUSY = 1'b1} pecc_snd_state_t;
endpackage : pecc_pkg
`default_nettype wire

// *** rtl/pecc_snd_if.sv ***
/*
  Carrier between the controller top and its fixed-buffer send engine.
  Assumes both ends run on the one core clock.
*/
`default_nettype none
interface pecc_snd_if;
  logic req;
  logic [4:0] conn;
  logic [7:0] unit;
  logic safety;
  logic tx_done;
  logic tx_req;
  logic done;
  logic err;
  logic [15:0] status;
  modport ctl (output req, conn, unit, safety, tx_done,
               input tx_req, done, err, status);
  modport eng (input req, conn, unit, safety, tx_done,
               output tx_req, done, err, status);
endinterface : pecc_snd_if
`default_nettype wire

// *** rtl/pecc_tick.sv ***
/*
  Periodic processing divider: one-cycle tick every POLL_CYCLES clocks.
  Assumes the core clock and its asynchronous active-low reset.
*/
`default_nettype none
`include "pecc_map.svh"
module pecc_tick #(
  parameter int unsigned POLL_CYCLES = `PECC_POLL_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic tick
);
  localparam int unsigned CW = $clog2(POLL_CYCLES) + 1;
  localparam logic [CW-1:0] LAST = CW'(POLL_CYCLES - 1);
  logic [CW-1:0] cnt_reg;
  wire wrap = cnt_reg == LAST;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_reg <= '0;
    else cnt_reg <= wrap ? '0 : cnt_reg + CW'(1);
  end
  assign tick = wrap;
endmodule : pecc_tick
`default_nettype wire

// *** rtl/pecc_send.sv ***
/*
  Fixed-buffer send engine: checks the setting data, then hands the send
  to the link and reports completion as one-cycle pulses.
  Assumes the link raises tx_done once per accepted tx_req.
*/
`default_nettype none
`include "pecc_map.svh"
module pecc_send
  import pecc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  pecc_snd_if.eng snd
);
  pecc_snd_state_t st_reg;
  logic done_reg;
  logic err_reg;
  logic [15:0] status_reg;
  wire [4:0] conn_max = snd.safety ? `PECC_MAX_SAFE : `PECC_MAX_CONN;
  wire conn_bad = (snd.conn == 5'h00) || (snd.conn > conn_max);
  wire unit_bad = snd.unit > `PECC_MAX_UNIT;
  wire take = snd.req && (st_reg == PECC_S_IDLE);
  wire [15:0] chk_code = (conn_bad && snd.safety) ? `PECC_E_OPER :
                         conn_bad ? `PECC_E_CONN :
                         unit_bad ? `PECC_E_UNIT : `PECC_OK;
  wire bad = chk_code != `PECC_OK;
  wire fin_ok = (st_reg == PECC_S_BUSY) && snd.tx_done;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= PECC_S_IDLE;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      status_reg <= `PECC_OK;
    end else begin
      done_reg <= (take && bad) || fin_ok;
      err_reg <= take && bad;
      if (take) status_reg <= chk_code;
      if (take && !bad) st_reg <= PECC_S_BUSY;
      else if (fin_ok) st_reg <= PECC_S_IDLE;
    end
  end
  assign snd.tx_req = st_reg == PECC_S_BUSY;
  assign snd.done = done_reg;
  assign snd.err = err_reg;
  assign snd.status = status_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_snd_pulse;
    snd.done |=> !snd.done;
  endproperty
  a_snd_pulse: assert property (p_snd_pulse) else $error("send done not one cycle");
  property p_snd_safe;
    take && snd.safety && conn_bad |=> snd.err && snd.status == `PECC_E_OPER;
  endproperty
  a_snd_safe: assert property (p_snd_safe) else $error("safety range not refused");
endmodule : pecc_send
`default_nettype wire

// *** verification/pecc_link_model.sv ***
/*
  Remote device partner: answers sends and receives of the controller.
  Assumes the controller's core clock and its active-low reset.
*/
`default_nettype none
module pecc_link_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] stall,
  input wire logic [2:0] stall_idx,
  input wire logic [15:0] types,
  input wire logic [2:0] proto_idx,
  output logic [1:0] proto_type,
  input wire logic tx_req,
  output logic tx_ack,
  output logic tx_done,
  input wire logic rx_en,
  output logic rx_start,
  output logic rx_done,
  output logic [4:0] rx_match,
  input wire logic snd_tx_req,
  output logic snd_tx_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tx_ph;
  logic rx_ph;
  wire logic [3:0] hold = (proto_idx == stall_idx) ? stall : 4'h0;
  assign proto_type = types[{proto_idx, 1'b0} +: 2];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ph <= 1'b0;
      rx_ph <= 1'b0;
      tx_ack <= 1'b0;
      tx_done <= 1'b0;
      rx_start <= 1'b0;
      rx_done <= 1'b0;
      rx_match <= 5'h00;
      snd_tx_done <= 1'b0;
    end else begin
      tx_ack <= 1'b0;
      tx_done <= 1'b0;
      rx_start <= 1'b0;
      rx_done <= 1'b0;
      rx_match <= ~rx_match;
      snd_tx_done <= snd_tx_req && !snd_tx_done;
      if (!tx_ph && tx_req && !tx_ack && !hold[0]) begin
        tx_ack <= 1'b1;
        tx_ph <= 1'b1;
      end else if (tx_ph && !hold[1]) begin
        tx_done <= 1'b1;
        tx_ph <= 1'b0;
      end
      if (!rx_ph && rx_en && !rx_start && !rx_done && !hold[2]) begin
        rx_start <= 1'b1;
        rx_ph <= 1'b1;
      end else if (rx_ph && !hold[3]) begin
        rx_done <= 1'b1;
        rx_ph <= 1'b0;
        rx_match <= 5'(proto_idx) + 5'h03;
      end
    end
  end
endmodule : pecc_link_model
`default_nettype wire

// *** verification/pecc_top_bench.sv ***
/*
  Self-checking bench of the protocol execute / cancel controller.
  Assumes the design files and the link partner model are compiled first.
*/
`default_nettype none
`include "pecc_map.svh"
`define PECC_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module pecc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POLL = 4;
  logic CORE_CLK, ARST_N, REG_WR, REG_RD, EXEC_REQ, EXEC_SETTING_OK, EXEC_DONE, EXEC_ERR;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, EXEC_STATUS, SND_STATUS, types, e16;
  logic [3:0] EXEC_NUM, EXEC_COUNT, stall;
  logic [4:0] EXEC_CONN, RX_MATCH, SND_CONN;
  logic [2:0] PROTO_IDX, stall_idx;
  logic [1:0] PROTO_TYPE;
  logic TX_REQ, TX_ACK, TX_DONE, RX_EN, RX_START, RX_DONE, RX_ERR, RX_DISCARD, SND_REQ;
  logic SAFETY_CPU, SND_TX_REQ, SND_TX_DONE, SND_DONE, SND_ERR, rd_pend, ed_last, sd_last;
  logic [7:0] SND_UNIT;
  logic [20:0] e21;
  logic [16:0] e17;
  logic [20:0] eq[$];
  logic [16:0] sq[$];
  logic [15:0] rq[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int s;
  pecc_top #(.POLL_CYCLES(POLL)) DUT (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .EXEC_REQ(EXEC_REQ), .EXEC_NUM(EXEC_NUM), .EXEC_CONN(EXEC_CONN),
    .EXEC_SETTING_OK(EXEC_SETTING_OK), .EXEC_DONE(EXEC_DONE), .EXEC_ERR(EXEC_ERR),
    .EXEC_STATUS(EXEC_STATUS), .EXEC_COUNT(EXEC_COUNT), .PROTO_IDX(PROTO_IDX),
    .PROTO_TYPE(PROTO_TYPE), .TX_REQ(TX_REQ), .TX_ACK(TX_ACK), .TX_DONE(TX_DONE),
    .RX_EN(RX_EN), .RX_START(RX_START), .RX_DONE(RX_DONE), .RX_ERR(RX_ERR),
    .RX_MATCH(RX_MATCH), .RX_DISCARD(RX_DISCARD), .SND_REQ(SND_REQ), .SND_CONN(SND_CONN),
    .SND_UNIT(SND_UNIT), .SAFETY_CPU(SAFETY_CPU), .SND_TX_REQ(SND_TX_REQ),
    .SND_TX_DONE(SND_TX_DONE), .SND_DONE(SND_DONE), .SND_ERR(SND_ERR),
    .SND_STATUS(SND_STATUS));
  pecc_link_model LINK (.clk(CORE_CLK), .arst_n(ARST_N), .stall(stall),
    .stall_idx(stall_idx), .types(types), .proto_idx(PROTO_IDX), .proto_type(PROTO_TYPE),
    .tx_req(TX_REQ), .tx_ack(TX_ACK), .tx_done(TX_DONE), .rx_en(RX_EN),
    .rx_start(RX_START), .rx_done(RX_DONE), .rx_match(RX_MATCH),
    .snd_tx_req(SND_TX_REQ), .snd_tx_done(SND_TX_DONE));
  always #50 CORE_CLK = ~CORE_CLK;
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Result watcher: oldest note against each completion or read
  always @(posedge CORE_CLK) begin
    cyc++;
    if (rd_pend) begin
      e16 = rq.pop_front();
      `PECC_CHK(REG_RDATA, e16)
    end
    if (EXEC_DONE) begin
      `PECC_CHK(eq.size() != 0, 1'b1)
      if (eq.size() != 0) e21 = eq.pop_front();
      `PECC_CHK({EXEC_ERR, EXEC_STATUS, EXEC_COUNT}, e21)
      `PECC_CHK(ed_last, 1'b0)
    end
    if (SND_DONE) begin
      `PECC_CHK(sq.size() != 0, 1'b1)
      if (sq.size() != 0) e17 = sq.pop_front();
      `PECC_CHK({SND_ERR, SND_STATUS}, e17)
      `PECC_CHK(sd_last, 1'b0)
    end
    if (EXEC_ERR || SND_ERR) begin
      `PECC_CHK({EXEC_ERR && !EXEC_DONE, SND_ERR && !SND_DONE}, 2'b00)
    end
    rd_pend = REG_RD;
    ed_last = EXEC_DONE;
    sd_last = SND_DONE;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
  endtask : rd
  task automatic ex(input logic [3:0] num, input logic ok, input logic [4:0] conn);
    @(posedge CORE_CLK);
    EXEC_REQ <= 1'b1;
    EXEC_NUM <= num;
    EXEC_SETTING_OK <= ok;
    EXEC_CONN <= conn;
    @(posedge CORE_CLK);
    EXEC_REQ <= 1'b0;
  endtask : ex
  task automatic settle;
    for (int i = 0; i < 300 && eq.size() + sq.size() + rq.size() != 0; i++) tick(1);
    tick(3);
    `PECC_CHK(eq.size() + sq.size() + rq.size(), 0)
  endtask : settle
  task automatic snd(input logic [4:0] c, input logic [7:0] u, input logic sf,
                     input logic [16:0] e);
    sq.push_back(e);
    @(posedge CORE_CLK);
    SND_REQ <= 1'b1;
    SND_CONN <= c;
    SND_UNIT <= u;
    SAFETY_CPU <= sf;
    @(posedge CORE_CLK);
    SND_REQ <= 1'b0;
    settle();
  endtask : snd
  initial begin
    {CORE_CLK, ARST_N, REG_WR, REG_RD, EXEC_REQ, EXEC_SETTING_OK, RX_ERR} = '0;
    {SND_REQ, SAFETY_CPU, REG_ADDR, REG_WDATA, EXEC_NUM, EXEC_CONN, SND_CONN} = '0;
    {SND_UNIT, types, stall, stall_idx, rd_pend, ed_last, sd_last} = '0;
    void'($urandom(54));
    tick(3);
    ARST_N <= 1'b1;
    rd(`PECC_A_STATE, `PECC_ST_IDLE);
    rd(`PECC_A_CANCEL, 16'h0000);
    wr(16'h1234, 16'hFFFF);
    rd(16'h1234, 16'h0000);
    wr(`PECC_A_STATE, 16'h0005);
    rd(`PECC_A_STATE, `PECC_ST_IDLE);
    wr(`PECC_A_CONN, 16'hFFFF);
    rd(`PECC_A_CONN, 16'hFFFF);
    settle();
    $display("test registers done");
    types <= 16'hFFFE;
    eq.push_back({1'b0, `PECC_OK, 4'h2});
    ex(4'h2, 1'b1, 5'($urandom_range(16, 1)));
    settle();
    rd(`PECC_A_MATCH, 16'h0003);
    rd(`PECC_A_MATCH + 16'h0001, 16'h0004);
    rd(`PECC_A_MATCH + 16'h0002, 16'h0000);
    settle();
    $display("test normal run done");
    for (int k = 0; k < 6; k++) begin
      if (k == 5) wr(`PECC_A_CONN, 16'hFFFE);
      eq.push_back({1'b1, k < 2 ? `PECC_E_CTRL : k == 2 ? `PECC_E_SET : `PECC_E_CONN, 4'h0});
      ex(k == 0 ? 4'h0 : k == 1 ? 4'h9 : 4'h1, k != 2, k == 3 ? 5'h00 : k == 4 ? 5'h11 : 5'h01);
      settle();
    end
    wr(`PECC_A_CONN, 16'hFFFF);
    stall <= 4'h8;
    ex(4'h1, 1'b1, 5'h01);
    tick(8);
    eq.push_back({1'b1, `PECC_E_PROTO, 4'h1});
    RX_ERR <= 1'b1;
    tick(1);
    RX_ERR <= 1'b0;
    stall <= 4'h0;
    settle();
    $display("test error codes done");
    wr(`PECC_A_CANCEL, `PECC_CANCEL_REQ);
    tick(3 * POLL + 2);
    rd(`PECC_A_STATE, `PECC_ST_IDLE);
    wr(`PECC_A_CANCEL, 16'h0000);
    types <= 16'h5555;
    eq.push_back({1'b0, `PECC_OK, 4'h1});
    ex(4'h1, 1'b1, 5'h01);
    settle();
    $display("test idle cancel done");
    for (int c = 0; c < 5; c++) begin
      s = (c == 4) ? 1 : c + 1;
      types <= (c < 2) ? 16'h5555 : 16'hFFFF;
      stall <= 4'h1 << (s - 1);
      stall_idx <= 3'(c == 4);
      ex(4'h3, 1'b1, 5'h01);
      tick(12);
      rd(`PECC_A_STATE, 16'(s));
      wr(`PECC_A_CANCEL, `PECC_CANCEL_REQ);
      if (s == 1 || s == 3) begin
        eq.push_back({1'b1, `PECC_E_CANCEL, 4'(c == 4) + 4'h1});
      end
      tick(3 * POLL + 2);
      if (s == 2 || s == 4) begin
        rd(`PECC_A_STATE, 16'(s));
        settle();
        eq.push_back({1'b1, `PECC_E_CANCEL, 4'h1});
      end
      stall <= 4'h0;
      settle();
      `PECC_CHK(RX_DISCARD, c > 1)
      rd(`PECC_A_STATE, `PECC_ST_IDLE);
      rd(`PECC_A_MATCH, c > 2 ? 16'h0003 : 16'h0000);
      ex(4'h1, 1'b1, 5'h01);
      tick(3 * POLL);
      settle();
      wr(`PECC_A_CANCEL, 16'h0000);
      settle();
    end
    $display("test cancel states done");
    snd(5'h01, 8'($urandom_range(254, 0)), 1'b0, {1'b0, `PECC_OK});
    snd(5'h10, 8'hFE, 1'b0, {1'b0, `PECC_OK});
    snd(5'h00, 8'($urandom_range(254, 0)), 1'b0, {1'b1, `PECC_E_CONN});
    snd(5'h11, 8'h00, 1'b0, {1'b1, `PECC_E_CONN});
    snd(5'h01, 8'hFF, 1'b0, {1'b1, `PECC_E_UNIT});
    snd(5'h09, 8'h00, 1'b1, {1'b1, `PECC_E_OPER});
    snd(5'h00, 8'h00, 1'b1, {1'b1, `PECC_E_OPER});
    snd(5'h08, 8'($urandom_range(254, 0)), 1'b1, {1'b0, `PECC_OK});
    $display("test fixed buffer send done");
    end_sim();
  end
endmodule : pecc_top_bench
`default_nettype wire
